// File: verilog/sdio_pkg.sv
// package: function codes, field layouts and reset values for the servo digital i/o decoder
// What this block does
// - rising edge on home-move input in internal position mode starts a home move
// - jog-forward input held active jogs forward in all modes except CAN
// - jog-reverse input held active jogs reverse in all modes except CAN
// - in external pulse mode two gear select inputs form the numerator index
// - in external pulse mode pulse inhibit input blocks and stops counting pulses
// - an input assigned function value zero is disabled and triggers nothing
// - ready output only when ready to run and no alarm present
// - power-on output whenever control power applied, regardless of alarm
// - zero-speed output while speed at or below range, clears above range
// - target-speed output asserts once speed reaches target speed
// - target-speed output stays until speed falls below target
// - internal position mode and external pulse mode are distinguished
package sdio_pkg;
	localparam int NUM_DI = 8;
	localparam int FUNC_W = 8;
	localparam int SPEED_W = 16;
	localparam int PULSE_CNT_W = 32;
	// input function codes
	localparam logic [7:0] FN_NONE = 8'h00;
	localparam logic [7:0] FN_GO_HOME = 8'h27;
	localparam logic [7:0] FN_JOG_FWD = 8'h37;
	localparam logic [7:0] FN_JOG_REV = 8'h38;
	localparam logic [7:0] FN_GEAR0 = 8'h43;
	localparam logic [7:0] FN_GEAR1 = 8'h44;
	localparam logic [7:0] FN_INHIBIT = 8'h45;
	// output function codes
	localparam logic [7:0] FO_READY = 8'h01;
	localparam logic [7:0] FO_PWR_ON = 8'h02;
	localparam logic [7:0] FO_ZERO_SPD = 8'h03;
	localparam logic [7:0] FO_TGT_SPD = 8'h04;
	localparam logic [15:0] ZERO_SPD_RANGE_RST = 16'h000A;
	localparam int INHIBIT_DI_REC = 7;

	typedef enum logic [1:0] {
		SDIO_MODE_PR  = 2'b00,
		SDIO_MODE_PT  = 2'b01,
		SDIO_MODE_CAN = 2'b11,
		SDIO_MODE_OTH = 2'b10
	} sdio_mode_t;

	typedef struct packed {
		logic       goHome;
		logic       jogFwd;
		logic       jogRev;
		logic [1:0] gearSel;
		logic       pulseInhibit;
	} sdio_cmd_t;

	typedef struct packed {
		logic readyOut;
		logic powerOnOut;
		logic zeroSpeedOut;
		logic targetReachedOut;
	} sdio_stat_t;
endpackage

// File: verilog/sdio_io_functions.sv
// module: servo digital input decode and status output generation
`timescale 1ns/1ps
module sdio_io_functions
	import sdio_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic [NUM_DI-1:0]             diPins,
	input  wire logic [NUM_DI-1:0][FUNC_W-1:0] diFunc,
	input  wire sdio_mode_t                    ctrlMode,
	input  wire logic                          ctrlPowerOn,
	input  wire logic                          runReady,
	input  wire logic                          alarmActive,
	input  wire logic [SPEED_W-1:0]            motorSpeed,
	input  wire logic [SPEED_W-1:0]            zeroSpeedRange,
	input  wire logic [SPEED_W-1:0]            targetSpeed,
	input  wire logic                          extPulse,
	output sdio_cmd_t                          cmdOut,
	output sdio_stat_t                         statOut,
	output logic [PULSE_CNT_W-1:0]             pulseCount
);

	// ----------------------------------------
	// input synchronisers and edge detect
	// ----------------------------------------
	logic [NUM_DI-1:0] syncA_q, syncA_d, syncB_q, syncB_d, prev_q, prev_d;

	always_comb begin
		syncA_d = diPins;
		syncB_d = syncA_q;
		prev_d = syncB_q;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			syncA_q <= '0;
			syncB_q <= '0;
			prev_q <= '0;
		end else begin
			syncA_q <= syncA_d;
			syncB_q <= syncB_d;
			prev_q <= prev_d;
		end
	end

	// ----------------------------------------
	// function decode
	// ----------------------------------------
	logic [NUM_DI-1:0] hitHome, hitJogF, hitJogR, hitG0, hitG1, hitInh;
	logic [NUM_DI-1:0] mHome, mFwd, mRev, mG0, mG1, mInh;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DI; gi++) begin : g_di
			// zero never matches a code, so an unassigned input does nothing
			logic en;
			assign en = (diFunc[gi] != FN_NONE);
			assign hitHome[gi] = en && diFunc[gi] == FN_GO_HOME
				&& syncB_q[gi] && !prev_q[gi];
			assign hitJogF[gi] = en && diFunc[gi] == FN_JOG_FWD && syncB_q[gi];
			assign hitJogR[gi] = en && diFunc[gi] == FN_JOG_REV && syncB_q[gi];
			assign hitG0[gi] = en && diFunc[gi] == FN_GEAR0 && syncB_q[gi];
			assign hitG1[gi] = en && diFunc[gi] == FN_GEAR1 && syncB_q[gi];
			assign hitInh[gi] = en && diFunc[gi] == FN_INHIBIT && syncB_q[gi];
			assign mHome[gi] = (diFunc[gi] == FN_GO_HOME);
			assign mFwd[gi] = (diFunc[gi] == FN_JOG_FWD);
			assign mRev[gi] = (diFunc[gi] == FN_JOG_REV);
			assign mG0[gi] = (diFunc[gi] == FN_GEAR0);
			assign mG1[gi] = (diFunc[gi] == FN_GEAR1);
			assign mInh[gi] = (diFunc[gi] == FN_INHIBIT);

			// per input: the synced level reaches its output one edge later
			chk_home_rise_fires: assert property (@(posedge clk) disable iff (!nrst)
				(isPr && diFunc[gi] == FN_GO_HOME && $rose(syncB_q[gi]))
				|=> cmdOut.goHome)
				else $error("home edge missed");

			chk_jog_fwd_level: assert property (@(posedge clk) disable iff (!nrst)
				(ctrlMode != SDIO_MODE_CAN && diFunc[gi] == FN_JOG_FWD && syncB_q[gi])
				|=> cmdOut.jogFwd)
				else $error("jog fwd level missed");

			chk_jog_rev_level: assert property (@(posedge clk) disable iff (!nrst)
				(ctrlMode != SDIO_MODE_CAN && diFunc[gi] == FN_JOG_REV && syncB_q[gi])
				|=> cmdOut.jogRev)
				else $error("jog rev level missed");

			chk_gear_low_level: assert property (@(posedge clk) disable iff (!nrst)
				(ctrlMode == SDIO_MODE_PT && diFunc[gi] == FN_GEAR0 && syncB_q[gi])
				|=> cmdOut.gearSel[0])
				else $error("gear bit 0 missed");

			chk_gear_high_level: assert property (@(posedge clk) disable iff (!nrst)
				(ctrlMode == SDIO_MODE_PT && diFunc[gi] == FN_GEAR1 && syncB_q[gi])
				|=> cmdOut.gearSel[1])
				else $error("gear bit 1 missed");

			chk_inhibit_level: assert property (@(posedge clk) disable iff (!nrst)
				(ctrlMode == SDIO_MODE_PT && diFunc[gi] == FN_INHIBIT && syncB_q[gi])
				|=> cmdOut.pulseInhibit)
				else $error("inhibit level missed");

			chk_unassigned_quiet: assert property (@(posedge clk) disable iff (!nrst)
				diFunc[gi] == FN_NONE
				|-> !(hitHome[gi] || hitJogF[gi] || hitJogR[gi] || hitG0[gi] || hitG1[gi] || hitInh[gi]))
				else $error("unassigned input decoded");
		end
	endgenerate

	// ----------------------------------------
	// command and status outputs
	// ----------------------------------------
	sdio_cmd_t cmd_q, cmd_d;
	sdio_stat_t stat_q, stat_d;
	logic [PULSE_CNT_W-1:0] cnt_q, cnt_d;
	logic isPr, isPt, notCan;

	assign isPr = (ctrlMode == SDIO_MODE_PR);
	assign isPt = (ctrlMode == SDIO_MODE_PT);
	assign notCan = (ctrlMode != SDIO_MODE_CAN);

	// ----------------------------------------
	// command group: decoded levels and the home pulse
	// ----------------------------------------
	always_comb begin
		cmd_d.goHome = isPr && |hitHome;
		cmd_d.jogFwd = notCan && |hitJogF;
		cmd_d.jogRev = notCan && |hitJogR;
		// gear index holds 0 outside pulse mode
		cmd_d.gearSel = isPt ? {|hitG1, |hitG0} : 2'h0;
		cmd_d.pulseInhibit = isPt && |hitInh;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cmd_q <= '0;
		end else begin
			cmd_q <= cmd_d;
		end
	end

	// ----------------------------------------
	// status group: power, ready and speed compares
	// ----------------------------------------
	always_comb begin
		stat_d.readyOut = ctrlPowerOn && runReady && !alarmActive;
		stat_d.powerOnOut = ctrlPowerOn;
		stat_d.zeroSpeedOut = (motorSpeed <= zeroSpeedRange);
		// reached sets at target, held until speed drops below target
		stat_d.targetReachedOut = (motorSpeed >= targetSpeed);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stat_q <= '0;
		end else begin
			stat_q <= stat_d;
		end
	end

	// ----------------------------------------
	// pulse counter group
	// ----------------------------------------
	always_comb begin
		cnt_d = cnt_q;
		// the inhibit sample lags its pin by the synchroniser; pulses in that gap still count
		if (extPulse && !(isPt && |hitInh)) begin
			cnt_d = cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign cmdOut = cmd_q;
	assign statOut = stat_q;
	assign pulseCount = cnt_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_home_one_pulse: assert property (@(posedge clk) disable iff (!nrst)
		cmdOut.goHome |=> !cmdOut.goHome) else $error("home pulse longer than one cycle");
	chk_home_mode_gate: assert property (@(posedge clk) disable iff (!nrst)
		cmdOut.goHome |-> $past(isPr)) else $error("home outside internal position");
	chk_jog_fwd_can: assert property (@(posedge clk) disable iff (!nrst)
		$past(ctrlMode) == SDIO_MODE_CAN |-> !cmdOut.jogFwd) else $error("jog fwd in CAN");
	chk_jog_rev_can: assert property (@(posedge clk) disable iff (!nrst)
		$past(ctrlMode) == SDIO_MODE_CAN |-> !cmdOut.jogRev) else $error("jog rev in CAN");
	chk_gear_pt_only: assert property (@(posedge clk) disable iff (!nrst)
		!$past(isPt) |-> cmdOut.gearSel == 2'h0) else $error("gear outside pulse mode");
	chk_inhibit_count: assert property (@(posedge clk) disable iff (!nrst)
		(isPt && |hitInh) |=> $stable(pulseCount)) else $error("pulse counted inhibited");
	chk_zero_func_off: assert property (@(posedge clk) disable iff (!nrst)
		(diFunc == '0) [*2] |=> !cmdOut.jogFwd && !cmdOut.goHome) else $error("unassigned fired");
	chk_ready_alarm: assert property (@(posedge clk) disable iff (!nrst)
		alarmActive |=> !statOut.readyOut) else $error("ready during alarm");
	chk_power_on: assert property (@(posedge clk) disable iff (!nrst)
		ctrlPowerOn |=> statOut.powerOnOut) else $error("power output missing");
	chk_zero_speed: assert property (@(posedge clk) disable iff (!nrst)
		(motorSpeed > zeroSpeedRange) |=> !statOut.zeroSpeedOut) else $error("zero speed wrong");
	chk_target_hold: assert property (@(posedge clk) disable iff (!nrst)
		(motorSpeed >= targetSpeed) |=> statOut.targetReachedOut) else $error("target not set");

	// ----------------------------------------
	// checks: outputs against their sources
	// ----------------------------------------
	chk_jog_fwd_src: assert property (@(posedge clk) disable iff (!nrst)
		cmdOut.jogFwd
		|-> $past((syncB_q & mFwd) != '0))
		else $error("jog fwd without input");

	chk_jog_rev_src: assert property (@(posedge clk) disable iff (!nrst)
		cmdOut.jogRev
		|-> $past((syncB_q & mRev) != '0))
		else $error("jog rev without input");

	chk_gear_index: assert property (@(posedge clk) disable iff (!nrst)
		$past(ctrlMode) == SDIO_MODE_PT
		|-> cmdOut.gearSel == {$past((syncB_q & mG1) != '0), $past((syncB_q & mG0) != '0)})
		else $error("gear index wrong");

	chk_gear_idle: assert property (@(posedge clk) disable iff (!nrst)
		($past(ctrlMode) == SDIO_MODE_PT && $past((syncB_q & (mG0 | mG1)) == '0))
		|-> cmdOut.gearSel == 2'h0)
		else $error("gear index without inputs");

	chk_inhibit_mode: assert property (@(posedge clk) disable iff (!nrst)
		$past(ctrlMode) != SDIO_MODE_PT
		|-> !cmdOut.pulseInhibit)
		else $error("inhibit outside pulse mode");

	chk_count_step: assert property (@(posedge clk) disable iff (!nrst)
		(extPulse && !(ctrlMode == SDIO_MODE_PT && (syncB_q & mInh) != '0))
		|=> pulseCount == $past(pulseCount) + 32'h0000_0001)
		else $error("pulse not counted");

	chk_count_idle: assert property (@(posedge clk) disable iff (!nrst)
		!extPulse
		|=> $stable(pulseCount))
		else $error("count moved without pulse");

	chk_home_needs_rise: assert property (@(posedge clk) disable iff (!nrst)
		cmdOut.goHome
		|-> ($past(syncB_q & mHome) & ~$past(syncB_q, 2)) != '0)
		else $error("home without rising edge");

	chk_home_pt_off: assert property (@(posedge clk) disable iff (!nrst)
		$past(ctrlMode) == SDIO_MODE_PT
		|-> !cmdOut.goHome)
		else $error("home in pulse mode");

	chk_ready_set: assert property (@(posedge clk) disable iff (!nrst)
		(ctrlPowerOn && runReady && !alarmActive)
		|=> statOut.readyOut)
		else $error("ready missing");

	chk_ready_not_run: assert property (@(posedge clk) disable iff (!nrst)
		!runReady
		|=> !statOut.readyOut)
		else $error("ready while not runnable");

	chk_ready_unpowered: assert property (@(posedge clk) disable iff (!nrst)
		!ctrlPowerOn
		|=> !statOut.readyOut)
		else $error("ready without power");

	chk_power_off: assert property (@(posedge clk) disable iff (!nrst)
		!ctrlPowerOn
		|=> !statOut.powerOnOut)
		else $error("power output without power");

	chk_power_alarm: assert property (@(posedge clk) disable iff (!nrst)
		(ctrlPowerOn && alarmActive)
		|=> statOut.powerOnOut && !statOut.readyOut)
		else $error("power output wrong in alarm");

	chk_zero_set: assert property (@(posedge clk) disable iff (!nrst)
		(motorSpeed <= zeroSpeedRange)
		|=> statOut.zeroSpeedOut)
		else $error("zero speed missing");

	chk_target_clear: assert property (@(posedge clk) disable iff (!nrst)
		(motorSpeed < targetSpeed)
		|=> !statOut.targetReachedOut)
		else $error("target held below target");

	// ----------------------------------------
	// coverage
	// ----------------------------------------

	cov_home_move: cover property (@(posedge clk) disable iff (!nrst) cmdOut.goHome);
	cov_jog_both: cover property (@(posedge clk) disable iff (!nrst) cmdOut.jogFwd ##1 cmdOut.jogRev);
	cov_gear_three: cover property (@(posedge clk) disable iff (!nrst) cmdOut.gearSel == 2'h3);
	cov_inhibit: cover property (@(posedge clk) disable iff (!nrst) cmdOut.pulseInhibit && extPulse);
	cov_target_drop: cover property (@(posedge clk) disable iff (!nrst)
		statOut.targetReachedOut ##1 !statOut.targetReachedOut);
endmodule

// File: test/sdio_ctl_model.sv
// partner model: machine controller driving the drive's inputs and command pulses
`timescale 1ns/1ps
module sdio_ctl_model
	import sdio_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [NUM_DI-1:0] pinReq,
	input  wire logic              pulseReq,
	output logic      [NUM_DI-1:0] diPins,
	output logic                   extPulse
);
	// contacts switch cleanly on the clock; bounce is not modelled
	always_ff @(posedge clk) begin
		diPins   <= pinReq;
		extPulse <= pulseReq;
	end
endmodule

// File: test/tb.sv
// testbench: directed checks of input decode and status outputs
`timescale 1ns/1ps
module tb;
	import sdio_pkg::*;
	logic                          clk = 1'b0;
	logic                          nrst = 1'b0;
	logic [7:0]                    pinReq = 8'h00;
	logic                          pulseReq = 1'b0;
	logic [7:0]                    diPins;
	logic                          extPulse;
	logic [NUM_DI-1:0][FUNC_W-1:0] diFunc = '0;
	sdio_mode_t                    ctrlMode = SDIO_MODE_PR;
	logic                          pwr = 1'b0;
	logic                          rdy = 1'b0;
	logic                          alm = 1'b0;
	logic [15:0]                   speed = 16'h0000;
	logic [15:0]                   zrng = ZERO_SPD_RANGE_RST;
	logic [15:0]                   tgt = 16'h0064;
	sdio_cmd_t                     cmdOut;
	sdio_stat_t                    statOut;
	logic [31:0]                   pulseCount;
	logic [31:0]                   base;
	int                            mismatches = 0;
	int                            tests_run = 0;
	int                            hits;
	always #2.5 clk = ~clk;
	sdio_ctl_model sdio_ctl_model_inst (.clk(clk), .pinReq(pinReq), .pulseReq(pulseReq),
		.diPins(diPins), .extPulse(extPulse));
	sdio_io_functions sdio_io_functions_inst (.clk(clk), .nrst(nrst), .diPins(diPins),
		.diFunc(diFunc), .ctrlMode(ctrlMode), .ctrlPowerOn(pwr), .runReady(rdy),
		.alarmActive(alm), .motorSpeed(speed), .zeroSpeedRange(zrng),
		.targetSpeed(tgt), .extPulse(extPulse), .cmdOut(cmdOut), .statOut(statOut),
		.pulseCount(pulseCount));
	// sample on the falling edge so registered outputs have settled
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic stat(input logic p, input logic a, input logic [15:0] s, input logic [3:0] e);
		@(posedge clk);
		pwr <= p;
		alm <= a;
		speed <= s;
		step(1);
		chk("statOut", {28'h0, e}, statOut);
	endtask
	task automatic home(input sdio_mode_t m, input logic [7:0] f, input logic [13:0] pat,
		input logic [31:0] e);
		hits = 0;
		for (int i = 0; i < 14; i++) begin
			@(posedge clk);
			ctrlMode <= m;
			diFunc[0] <= f;
			pinReq[0] <= pat[i];
			@(negedge clk);
			hits += int'(cmdOut.goHome);
		end
		chk("goHome", e, hits);
	endtask
	task automatic pulses(input logic [31:0] e);
		@(negedge clk);
		base = pulseCount;
		repeat (3) begin
			@(posedge clk);
			pulseReq <= 1'b1;
			@(posedge clk);
			pulseReq <= 1'b0;
		end
		step(3);
		chk("pulseCount", e, pulseCount - base);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rdy <= 1'b1;
		stat(1'b1, 1'b0, 16'h000A, 4'hE);
		stat(1'b1, 1'b1, 16'h000B, 4'h4);
		stat(1'b1, 1'b0, 16'h0064, 4'hD);
		stat(1'b1, 1'b0, 16'h0063, 4'hC);
		@(posedge clk);
		zrng <= 16'h0020;
		tgt <= 16'h0010;
		stat(1'b1, 1'b0, 16'h0011, 4'hF);
		@(posedge clk);
		zrng <= ZERO_SPD_RANGE_RST;
		tgt <= 16'h0064;
		home(SDIO_MODE_PR, FN_GO_HOME, 14'h0067, 2);
		home(SDIO_MODE_PT, FN_GO_HOME, 14'h0007, 0);
		home(SDIO_MODE_PR, FN_NONE, 14'h0007, 0);
		@(posedge clk);
		diFunc[1] <= FN_JOG_FWD;
		diFunc[2] <= FN_JOG_REV;
		diFunc[3] <= FN_GEAR0;
		diFunc[4] <= FN_GEAR1;
		diFunc[INHIBIT_DI_REC] <= FN_INHIBIT;
		pinReq <= 8'h06;
		step(6);
		chk("jog", 2'b11, {cmdOut.jogFwd, cmdOut.jogRev});
		for (int g = 0; g < 4; g++) begin
			@(posedge clk);
			ctrlMode <= SDIO_MODE_PT;
			pinReq <= 8'h06 | 8'(g << 3);
			step(6);
			chk("gearSel", g, cmdOut.gearSel);
		end
		@(posedge clk);
		ctrlMode <= SDIO_MODE_CAN;
		step(2);
		chk("jogCan", 0, {cmdOut.jogFwd, cmdOut.jogRev});
		chk("gearCan", 0, cmdOut.gearSel);
		@(posedge clk);
		ctrlMode <= SDIO_MODE_PT;
		pulses(3);
		@(posedge clk);
		pinReq <= 8'(1 << INHIBIT_DI_REC);
		step(6);
		chk("inhibit", 1, cmdOut.pulseInhibit);
		pulses(0);
		conclude();
	end
endmodule
